// ==== verilog/rmfb_regs.svh ====
// Constants for the retained data-memory flash backup block
`ifndef RMFB_REGS_SVH
`define RMFB_REGS_SVH
`define RMFB_ADDR_W 15
`define RMFB_DATA_W 16
`define RMFB_RET_FIRST 15'h4E20
`define RMFB_RET_LAST 15'h7FFF
`define RMFB_RET_WORDS 15'h31E0
`define RMFB_SRC_W 3
`define RMFB_SRC_TOOL 3'h0
`define RMFB_SRC_XFER 3'h1
`define RMFB_SRC_TERM 3'h2
`define RMFB_SRC_PROG 3'h3
`define RMFB_SRC_UNIT 3'h4
`endif

// ==== verilog/rmfb_pkg.sv ====
// Types for the retained data-memory flash backup block
package rmfb_pkg;
  typedef enum logic [4:0] {
    RMFB_IDLE = 5'h01,
    RMFB_RESTORE = 5'h02,
    RMFB_SAVE = 5'h04,
    RMFB_WAIT = 5'h08,
    RMFB_RUN = 5'h10
  } rmfb_state_t;
endpackage : rmfb_pkg

// ==== verilog/rmfb_trigger.sv ====
// Save trigger decode from tagged data-memory writes
`timescale 1ns/1ps
`default_nettype none
`include "rmfb_regs.svh"
module rmfb_trigger (
  input wire logic wr_en,
  input wire logic [`RMFB_ADDR_W-1:0] wr_addr,
  input wire logic [`RMFB_SRC_W-1:0] wr_src,
  output logic hit
);
  logic in_range;
  logic src_ok;
  always_comb
  begin
    in_range = (wr_addr >= `RMFB_RET_FIRST) && (wr_addr <= `RMFB_RET_LAST);
    src_ok = (wr_src == `RMFB_SRC_TOOL) || (wr_src == `RMFB_SRC_XFER)
      || (wr_src == `RMFB_SRC_TERM);
    hit = wr_en && in_range && src_ok;
  end
endmodule : rmfb_trigger
`default_nettype wire

// ==== verilog/rmfb_backup.sv ====
// Retained data-memory flash backup controller
`timescale 1ns/1ps
`default_nettype none
`include "rmfb_regs.svh"
module rmfb_backup (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [`RMFB_ADDR_W-1:0] wr_addr,
  input wire logic [`RMFB_SRC_W-1:0] wr_src,
  output logic dm_req_ff,
  output logic dm_we_ff,
  output logic [`RMFB_ADDR_W-1:0] dm_addr_ff,
  output logic [`RMFB_DATA_W-1:0] dm_wdata_ff,
  input wire logic [`RMFB_DATA_W-1:0] dm_rdata,
  output logic fl_req_ff,
  output logic fl_we_ff,
  output logic [`RMFB_ADDR_W-1:0] fl_addr_ff,
  output logic [`RMFB_DATA_W-1:0] fl_wdata_ff,
  input wire logic [`RMFB_DATA_W-1:0] fl_rdata,
  input wire logic fl_done,
  input wire logic fl_err,
  output logic init_done_ff,
  output logic saving_ff,
  output logic flash_fail_ff
);
  // Flash handshake: fl_req held until fl_done; fl_err valid with fl_done.
  // Data memory answers reads in the same cycle that dm_req is high.
  rmfb_pkg::rmfb_state_t state_ff, nxt_state;
  logic [`RMFB_ADDR_W-1:0] idx_ff, nxt_idx;
  logic pend_ff, nxt_pend;
  logic restore_ff, nxt_restore;
  logic phase_ff, nxt_phase;
  logic nxt_dm_req, nxt_dm_we, nxt_fl_req, nxt_fl_we;
  logic [`RMFB_ADDR_W-1:0] nxt_dm_addr, nxt_fl_addr;
  logic [`RMFB_DATA_W-1:0] nxt_dm_wdata, nxt_fl_wdata;
  logic nxt_init_done, nxt_saving, nxt_fail;
  logic hit;
  logic last;

  rmfb_trigger u_trigger (
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_src(wr_src),
    .hit(hit)
  );

  assign last = (idx_ff == `RMFB_RET_LAST);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_pend = pend_ff || hit;
    nxt_restore = restore_ff;
    nxt_phase = phase_ff;
    nxt_dm_req = 1'b0;
    nxt_dm_we = 1'b0;
    nxt_dm_addr = dm_addr_ff;
    nxt_dm_wdata = dm_wdata_ff;
    nxt_fl_req = fl_req_ff;
    nxt_fl_we = fl_we_ff;
    nxt_fl_addr = fl_addr_ff;
    nxt_fl_wdata = fl_wdata_ff;
    nxt_init_done = init_done_ff;
    nxt_saving = saving_ff;
    nxt_fail = flash_fail_ff;
    unique case (state_ff)
      rmfb_pkg::RMFB_IDLE:
      begin
        // Restore first; triggers seen meanwhile are kept pending
        nxt_idx = `RMFB_RET_FIRST;
        nxt_restore = 1'b1;
        nxt_fl_req = 1'b1;
        nxt_fl_we = 1'b0;
        nxt_fl_addr = `RMFB_RET_FIRST;
        nxt_state = rmfb_pkg::RMFB_WAIT;
      end
      rmfb_pkg::RMFB_RESTORE:
      begin
        nxt_dm_req = 1'b1;
        nxt_dm_we = 1'b1;
        nxt_dm_addr = idx_ff;
        nxt_dm_wdata = fl_rdata;
        if (last)
        begin
          nxt_init_done = 1'b1;
          nxt_state = rmfb_pkg::RMFB_RUN;
        end
        else
        begin
          nxt_idx = idx_ff + 15'h0001;
          nxt_fl_req = 1'b1;
          nxt_fl_we = 1'b0;
          nxt_fl_addr = idx_ff + 15'h0001;
          nxt_state = rmfb_pkg::RMFB_WAIT;
        end
      end
      rmfb_pkg::RMFB_WAIT:
      begin
        if (fl_done)
        begin
          nxt_fl_req = 1'b0;
          if (fl_err)
          begin
            nxt_fail = 1'b1;
          end
          if (restore_ff)
          begin
            nxt_state = rmfb_pkg::RMFB_RESTORE;
          end
          else if (last)
          begin
            nxt_saving = 1'b0;
            nxt_state = rmfb_pkg::RMFB_RUN;
          end
          else
          begin
            nxt_idx = idx_ff + 15'h0001;
            nxt_phase = 1'b0;
            nxt_state = rmfb_pkg::RMFB_SAVE;
          end
        end
      end
      rmfb_pkg::RMFB_SAVE:
      begin
        // Whole range copied word by word, read then program
        if (!phase_ff)
        begin
          nxt_dm_req = 1'b1;
          nxt_dm_addr = idx_ff;
          nxt_phase = 1'b1;
        end
        else
        begin
          nxt_fl_req = 1'b1;
          nxt_fl_we = 1'b1;
          nxt_fl_addr = idx_ff;
          nxt_fl_wdata = dm_rdata;
          nxt_state = rmfb_pkg::RMFB_WAIT;
        end
      end
      rmfb_pkg::RMFB_RUN:
      begin
        if (pend_ff)
        begin
          // Writes during a save re-arm one more full save
          nxt_pend = hit;
          nxt_restore = 1'b0;
          nxt_saving = 1'b1;
          nxt_idx = `RMFB_RET_FIRST;
          nxt_phase = 1'b0;
          nxt_state = rmfb_pkg::RMFB_SAVE;
        end
      end
      default:
      begin
        nxt_state = rmfb_pkg::RMFB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= rmfb_pkg::RMFB_IDLE;
      idx_ff <= `RMFB_RET_FIRST;
      pend_ff <= 1'b0;
      restore_ff <= 1'b0;
      phase_ff <= 1'b0;
      dm_req_ff <= 1'b0;
      dm_we_ff <= 1'b0;
      dm_addr_ff <= 15'h0000;
      dm_wdata_ff <= 16'h0000;
      fl_req_ff <= 1'b0;
      fl_we_ff <= 1'b0;
      fl_addr_ff <= 15'h0000;
      fl_wdata_ff <= 16'h0000;
      init_done_ff <= 1'b0;
      saving_ff <= 1'b0;
      flash_fail_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      pend_ff <= nxt_pend;
      restore_ff <= nxt_restore;
      phase_ff <= nxt_phase;
      dm_req_ff <= nxt_dm_req;
      dm_we_ff <= nxt_dm_we;
      dm_addr_ff <= nxt_dm_addr;
      dm_wdata_ff <= nxt_dm_wdata;
      fl_req_ff <= nxt_fl_req;
      fl_we_ff <= nxt_fl_we;
      fl_addr_ff <= nxt_fl_addr;
      fl_wdata_ff <= nxt_fl_wdata;
      init_done_ff <= nxt_init_done;
      saving_ff <= nxt_saving;
      flash_fail_ff <= nxt_fail;
    end
  end

  a_fail_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flash_fail_ff |=> flash_fail_ff) else $error("Fail flag dropped");
  a_fail_on_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == rmfb_pkg::RMFB_WAIT && fl_done && fl_err) |=> flash_fail_ff)
    else $error("Flash error not flagged");
  a_trig_save: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hit && state_ff == rmfb_pkg::RMFB_RUN && !pend_ff) |=> ##1 saving_ff)
    else $error("Trigger did not start save");
  a_no_prog_trig: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_en && (wr_src == `RMFB_SRC_PROG || wr_src == `RMFB_SRC_UNIT)) |-> !hit)
    else $error("Program or unit write triggered");
  a_range_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_en && wr_addr < `RMFB_RET_FIRST) |-> !hit)
    else $error("Out of range write triggered");
  a_save_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(saving_ff) |-> dm_addr_ff == `RMFB_RET_FIRST || idx_ff == `RMFB_RET_FIRST)
    else $error("Save did not begin at range start");
  a_save_wr_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fl_req_ff && fl_we_ff) |-> fl_addr_ff >= `RMFB_RET_FIRST)
    else $error("Flash write outside range");
  a_restore_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    saving_ff |-> init_done_ff) else $error("Save before restore ended");
endmodule : rmfb_backup
`default_nettype wire

// ==== testbench/rmfb_flash_model.sv ====
// Flash and data-memory read partner model
`timescale 1ns/1ps
`default_nettype none
module rmfb_flash_model (
  input wire logic sys_clk,
  input wire logic fl_req_ff,
  input wire logic fl_we_ff,
  input wire logic [14:0] fl_addr_ff,
  input wire logic dm_req_ff,
  input wire logic [14:0] dm_addr_ff,
  input wire logic [14:0] err_addr,
  output logic [15:0] fl_rdata,
  output logic fl_done,
  output logic fl_err,
  output logic [15:0] dm_rdata
);
  logic [15:0] dm_pat;
  // Stale data is inverted so a late sample is caught
  // Flash read data stands while the request is held, which covers the edge after done
  always_ff @(posedge sys_clk)
  begin
    fl_done <= fl_req_ff && !fl_done;
    fl_err <= fl_req_ff && !fl_done && !fl_we_ff && fl_addr_ff == err_addr;
    fl_rdata <= fl_req_ff ? {1'b0, fl_addr_ff} ^ 16'h3C3C : ~fl_rdata;
  end
  // Data memory answers within the cycle in which its request stands
  assign dm_pat = {1'b0, dm_addr_ff} ^ 16'hC3C3;
  assign dm_rdata = dm_req_ff ? dm_pat : ~dm_pat;
endmodule : rmfb_flash_model
`default_nettype wire

// ==== testbench/tb_retained_memory_flash_backup.sv ====
// Bench for the retained data-memory flash backup block
`timescale 1ns/1ps
`default_nettype none
`include "rmfb_regs.svh"
module tb_retained_memory_flash_backup;
  localparam logic [14:0] ERR_A = `RMFB_RET_LAST;
  logic sys_clk, rst_n, wr_en, fl_done, fl_err;
  logic dm_req_ff, dm_we_ff, fl_req_ff, fl_we_ff, init_done_ff, saving_ff, flash_fail_ff;
  logic [14:0] wr_addr, dm_addr_ff, fl_addr_ff;
  logic [2:0] wr_src;
  logic [15:0] dm_wdata_ff, dm_rdata, fl_wdata_ff, fl_rdata, x;
  logic [30:0] q_rst[$], q_sav[$];
  int n_errors, cmp_count;
  rmfb_backup dut_u (.sys_clk, .rst_n, .wr_en, .wr_addr, .wr_src, .dm_req_ff, .dm_we_ff,
    .dm_addr_ff, .dm_wdata_ff, .dm_rdata, .fl_req_ff, .fl_we_ff, .fl_addr_ff, .fl_wdata_ff,
    .fl_rdata, .fl_done, .fl_err, .init_done_ff, .saving_ff, .flash_fail_ff);
  rmfb_flash_model fm_u (.sys_clk, .fl_req_ff, .fl_we_ff, .fl_addr_ff, .dm_req_ff,
    .dm_addr_ff, .err_addr(ERR_A), .fl_rdata, .fl_done, .fl_err, .dm_rdata);
  task automatic chk(string nm, logic [30:0] seen, logic [30:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  function automatic logic [15:0] rnd(logic [15:0] v);
    v ^= v << 7;
    v ^= v >> 9;
    v ^= v << 8;
    return v;
  endfunction : rnd
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  initial
  begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    // Restore needs about 38300 cycles and a full save about 51100
    repeat (95000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end
  // Results are compared in arrival order against the noted expectations
  always @(posedge sys_clk)
  begin
    if (dm_req_ff && dm_we_ff && dm_addr_ff !== ERR_A)
      chk("restore", {dm_addr_ff, dm_wdata_ff}, q_rst.pop_front());
    if (fl_req_ff && fl_we_ff && fl_done)
      chk("save", {fl_addr_ff, fl_wdata_ff}, q_sav.pop_front());
  end
  initial
  begin
    rst_n = 0;
    wr_en = 0;
    wr_addr = '0;
    wr_src = '0;
    x = 16'h5997;
    for (int a = 20000; a <= 32767; a++)
    begin
      if (a < 32767)
        q_rst.push_back({a[14:0], a[15:0] ^ 16'h3C3C});
      q_sav.push_back({a[14:0], a[15:0] ^ 16'hC3C3});
    end
    for (int s = 0; s < 5; s++)
      for (int k = 0; k < 4; k++)
      begin
        x = rnd(x);
        wr_src = s[2:0];
        wr_addr = k == 0 ? 15'h4E1F : k == 1 ? `RMFB_RET_FIRST : k == 2 ? ERR_A : x[14:0];
        wr_en = k != 3 || x[15];
        #1;
        chk("trigger", dut_u.hit, wr_en && s < 3 && wr_addr >= `RMFB_RET_FIRST);
      end
    wr_en = 0;
    repeat (12) tick();
    chk("reset outs", {dm_req_ff, fl_req_ff, init_done_ff, saving_ff, flash_fail_ff}, '0);
    rst_n = 1;
    // Refused writes while restore runs
    for (int i = 0; i < 60; i++)
    begin
      tick();
      x = rnd(x);
      wr_en = 1;
      wr_src = i % 3 == 2 ? x[1:0] % 3 : 3'h3 + x[0];
      wr_addr = i % 3 == 2 ? x[14:0] % `RMFB_RET_FIRST : `RMFB_RET_FIRST + x[11:0];
    end
    tick();
    wr_en = 0;
    for (int i = 0; i < 60000 && init_done_ff !== 1'b1; i++)
      tick();
    chk("fail flag", flash_fail_ff, 1'b1);
    chk("restore left", q_rst.size(), 0);
    repeat (5) tick();
    chk("no save", saving_ff, 1'b0);
    // One triggering write only, to spare flash wear
    x = rnd(x);
    wr_en = 1;
    wr_src = x[1:0] % 3;
    wr_addr = `RMFB_RET_FIRST + x[12:0];
    tick();
    wr_en = 0;
    tick();
    chk("save start", saving_ff, 1'b1);
    for (int i = 0; i < 60000 && saving_ff !== 1'b0; i++)
      tick();
    chk("save left", q_sav.size(), 0);
    chk("fail sticky", flash_fail_ff, 1'b1);
    close_out();
  end
endmodule : tb_retained_memory_flash_backup
`default_nettype wire
